// ===== src/pll_scan_pkg.sv
/*
 Shared constants and types for the transceiver PLL scan-reconfiguration block.
 Assumes a 25 MHz system clock; the scan clock arrives as a pin and is sampled.
*/
package pll_scan_pkg;
  localparam int NUM_PLLS = 2;
  localparam int CHAIN_LEN = 18;
  localparam int CNT_W = 5;
  localparam int SYNC_STAGES = 2;
  // Scan chain field layout: multiplier, divider, rate select
  localparam int MULT_LSB = 0;
  localparam int MULT_W = 8;
  localparam int DIV_LSB = 8;
  localparam int DIV_W = 8;
  localparam int RATE_LSB = 16;
  localparam int RATE_W = 2;
  localparam logic [CHAIN_LEN-1:0] CHAIN_RESET = 18'h0_0101;
  localparam logic [CNT_W-1:0] DONE_HOLD_CYCLES = 5'h04;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_UPDATE = 2'b01,
    ST_DONE = 2'b11
  } upd_state_t;

  // Settings a PLL delivers to every channel it clocks
  typedef struct packed {
    logic [RATE_W-1:0] rate;
    logic [DIV_W-1:0] div;
    logic [MULT_W-1:0] mult;
  } pll_cfg_t;

  // One PLL's sampled scan-side inputs
  typedef struct packed {
    logic scanclk;
    logic scanclkena;
    logic scandata;
    logic configupdate;
    logic areset;
  } scan_pins_t;
endpackage

// ===== src/pll_scan_lane.sv
/*
 One PLL's scan chain: shift register, shadow settings and done handshake.
 Assumes inputs are already synchronised to clk_sys_in.
*/
`timescale 1ns/1ps
module pll_scan_lane (
  input wire logic clk_sys_in,                    // System clock
  input wire logic arst_n_in,                     // Async reset, active low
  input wire pll_scan_pkg::scan_pins_t pins_in,   // Synchronised scan pins
  output logic scandataout_out,                   // Chain tail, registered
  output logic reconfig_done_out,                 // Reprogramming finished
  output pll_scan_pkg::pll_cfg_t cfg_out          // Active PLL settings
);
  logic clk_d_r, clk_d_nxt;
  logic [pll_scan_pkg::CHAIN_LEN-1:0] chain_r, chain_nxt;
  pll_scan_pkg::pll_cfg_t cfg_r, cfg_nxt;
  pll_scan_pkg::upd_state_t st_r, st_nxt;
  logic [pll_scan_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
  logic done_r, done_nxt;
  logic rise;

  function automatic pll_scan_pkg::pll_cfg_t decode(input logic [pll_scan_pkg::CHAIN_LEN-1:0] c);
    pll_scan_pkg::pll_cfg_t r;
    r.mult = c[pll_scan_pkg::MULT_LSB +: pll_scan_pkg::MULT_W];
    r.div = c[pll_scan_pkg::DIV_LSB +: pll_scan_pkg::DIV_W];
    r.rate = c[pll_scan_pkg::RATE_LSB +: pll_scan_pkg::RATE_W];
    return r;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    rise = pins_in.scanclk & ~clk_d_r;
    clk_d_nxt = pins_in.scanclk;
    chain_nxt = chain_r;
    cfg_nxt = cfg_r;
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    done_nxt = done_r;
    // Shift only on enabled edges; chain runs MSB in, LSB out
    if (rise && pins_in.scanclkena) begin
      chain_nxt = {pins_in.scandata, chain_r[pll_scan_pkg::CHAIN_LEN-1:1]};
    end
    case (st_r)
      pll_scan_pkg::ST_IDLE: begin
        if (pins_in.configupdate) begin
          st_nxt = pll_scan_pkg::ST_UPDATE;
        end
      end
      pll_scan_pkg::ST_UPDATE: begin
        // Only the PLL settings load; channel settings live elsewhere
        cfg_nxt = decode(chain_r);
        cnt_nxt = pll_scan_pkg::DONE_HOLD_CYCLES;
        st_nxt = pll_scan_pkg::ST_DONE;
      end
      pll_scan_pkg::ST_DONE: begin
        done_nxt = 1'b1;
        if (cnt_r != '0) begin
          cnt_nxt = cnt_r - 1'b1;
        end else if (!pins_in.configupdate) begin
          st_nxt = pll_scan_pkg::ST_IDLE;
        end
      end
      default: st_nxt = pll_scan_pkg::ST_IDLE;
    endcase
    // Done stays high until the next scan or the PLL reset clears it
    if ((rise && pins_in.scanclkena) || pins_in.areset) begin
      done_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      clk_d_r <= 1'b0;
      chain_r <= pll_scan_pkg::CHAIN_RESET;
      cfg_r <= pll_scan_pkg::pll_cfg_t'(pll_scan_pkg::CHAIN_RESET);
      st_r <= pll_scan_pkg::ST_IDLE;
      cnt_r <= '0;
      done_r <= 1'b0;
    end else begin
      clk_d_r <= clk_d_nxt;
      chain_r <= chain_nxt;
      cfg_r <= cfg_nxt;
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      done_r <= done_nxt;
    end
  end

  assign scandataout_out = chain_r[0];
  assign reconfig_done_out = done_r;
  assign cfg_out = cfg_r;
endmodule

// ===== src/pll_scan_reconfig.sv
/*
 Transceiver PLL scan-reconfiguration target: one scan lane per PLL, reset
 handling and per-channel rate fan-out.
 Assumes an external controller drives scan pins from its own clock; all of
 them are treated as asynchronous and pass two flip-flops.
*/
// Functional notes
// - Channels clocked by a reprogrammed PLL follow its new data rate.
// - PLL reprogramming leaves other channel settings untouched.
// - Every scan port carries one bit per PLL, top index count minus one.
// - PLL takes reconfiguration bits on its serial scan data input.
// - Scan activity happens only while scan clock enable is high.
// - PLL raises reconfiguration-complete when reprogramming finishes.
// - Internal scan-complete drives the done output the controller reads.
// - PLL shifts its current configuration out on scan data output.
`timescale 1ns/1ps
module pll_scan_reconfig (
  input wire logic clk_sys_in,                                        // System clock, 25 MHz
  input wire logic arst_n_in,                                         // Async reset, active low
  input wire logic [pll_scan_pkg::NUM_PLLS-1:0] pll_areset_in,        // PLL reset per PLL
  input wire logic [pll_scan_pkg::NUM_PLLS-1:0] pll_scandata_in,      // Serial scan data
  input wire logic [pll_scan_pkg::NUM_PLLS-1:0] pll_scanclk_in,       // Scan clock
  input wire logic [pll_scan_pkg::NUM_PLLS-1:0] pll_scanclkena_in,    // Scan clock enable
  input wire logic [pll_scan_pkg::NUM_PLLS-1:0] pll_configupdate_in,  // Config update strobe
  output logic [pll_scan_pkg::NUM_PLLS-1:0] pll_reconfig_done_out,    // Reprogramming done
  output logic [pll_scan_pkg::NUM_PLLS-1:0] pll_scandataout_out,      // Config read-back
  output logic [pll_scan_pkg::NUM_PLLS-1:0] pll_locked_out,           // PLL out of reset
  output pll_scan_pkg::pll_cfg_t [pll_scan_pkg::NUM_PLLS-1:0] chan_cfg_out // Rate seen by channels
);
  localparam int N = pll_scan_pkg::NUM_PLLS;

  // Two stages per pin; stage one feeds only stage two
  pll_scan_pkg::scan_pins_t [N-1:0] meta_r, meta_nxt;
  pll_scan_pkg::scan_pins_t [N-1:0] sync_r, sync_nxt;
  logic [N-1:0] done_w, sdo_w;
  pll_scan_pkg::pll_cfg_t [N-1:0] cfg_w;
  logic [N-1:0] done_r, done_nxt;
  logic [N-1:0] sdo_r, sdo_nxt;
  logic [N-1:0] lock_r, lock_nxt;
  pll_scan_pkg::pll_cfg_t [N-1:0] chan_r, chan_nxt;

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    for (int i = 0; i < N; i++) begin
      meta_nxt[i].scanclk = pll_scanclk_in[i];
      meta_nxt[i].scanclkena = pll_scanclkena_in[i];
      meta_nxt[i].scandata = pll_scandata_in[i];
      meta_nxt[i].configupdate = pll_configupdate_in[i];
      meta_nxt[i].areset = pll_areset_in[i];
    end
    sync_nxt = meta_r;
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  for (genvar g = 0; g < N; g++) begin : g_lane
    pll_scan_lane u_lane (
      .clk_sys_in(clk_sys_in),
      .arst_n_in(arst_n_in),
      .pins_in(sync_r[g]),
      .scandataout_out(sdo_w[g]),
      .reconfig_done_out(done_w[g]),
      .cfg_out(cfg_w[g])
    );
  end

  //////////////////////////////////////////////////////////////////////////////
  // New settings reach channels only while the PLL sits in reset, so no
  // channel sees a half-updated rate.
  always_comb begin
    done_nxt = done_w;
    sdo_nxt = sdo_w;
    chan_nxt = chan_r;
    for (int i = 0; i < N; i++) begin
      lock_nxt[i] = ~sync_r[i].areset;
      if (sync_r[i].areset) begin
        chan_nxt[i] = cfg_w[i];
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      done_r <= '0;
      sdo_r <= '0;
      lock_r <= '0;
      chan_r <= {N{pll_scan_pkg::pll_cfg_t'(pll_scan_pkg::CHAIN_RESET)}};
    end else begin
      done_r <= done_nxt;
      sdo_r <= sdo_nxt;
      lock_r <= lock_nxt;
      chan_r <= chan_nxt;
    end
  end

  assign pll_reconfig_done_out = done_r;
  assign pll_scandataout_out = sdo_r;
  assign pll_locked_out = lock_r;
  assign chan_cfg_out = chan_r;
endmodule

// ===== test/pll_scan_checker.sv
/* Port assertions for the PLL scan-reconfiguration block.
 Bound to pll_scan_reconfig; sees only its ports, one clock domain. */
`timescale 1ns/1ps
module pll_scan_checker (
  input wire logic clk_sys_in, // System clock
  input wire logic arst_n_in, // Async reset
  input wire logic [pll_scan_pkg::NUM_PLLS-1:0] pll_areset_in, // PLL reset
  input wire logic [pll_scan_pkg::NUM_PLLS-1:0] pll_scanclk_in, // Scan clock
  input wire logic [pll_scan_pkg::NUM_PLLS-1:0] pll_scanclkena_in, // Scan enable
  input wire logic [pll_scan_pkg::NUM_PLLS-1:0] pll_configupdate_in, // Update strobe
  input wire logic [pll_scan_pkg::NUM_PLLS-1:0] pll_reconfig_done_out, // Done
  input wire logic [pll_scan_pkg::NUM_PLLS-1:0] pll_scandataout_out, // Read-back
  input wire logic [pll_scan_pkg::NUM_PLLS-1:0] pll_locked_out, // Out of reset
  input wire pll_scan_pkg::pll_cfg_t [pll_scan_pkg::NUM_PLLS-1:0] chan_cfg_out // Channel settings
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!arst_n_in);
  a_done_after_update: assert property ($rose(pll_configupdate_in[0]) |-> ##[1:10] pll_reconfig_done_out[0])
    else $error("done missing after update");
  a_done_needs_update: assert property (!pll_configupdate_in[1] [*8] |-> !$rose(pll_reconfig_done_out[1]))
    else $error("done without update");
  a_reset_clears_done: assert property (pll_areset_in[0] [*6] |-> !pll_reconfig_done_out[0])
    else $error("done held through reset");
  a_shift_clears_done: assert property ($rose(pll_scanclk_in[1]) && pll_scanclkena_in[1]
    |-> ##[1:6] !pll_reconfig_done_out[1])
    else $error("done kept after shift");
  a_locked_in_reset: assert property (pll_areset_in[1] [*6] |-> !pll_locked_out[1])
    else $error("locked during reset");
  a_locked_after_reset: assert property (!pll_areset_in[0] [*6] |-> pll_locked_out[0])
    else $error("not locked out of reset");
  a_cfg_held_run: assert property (!pll_areset_in[0] [*6] |-> $stable(chan_cfg_out[0]))
    else $error("channel settings moved");
  a_sdo_idle_hold: assert property (!pll_scanclkena_in[1] [*8] |-> $stable(pll_scandataout_out[1]))
    else $error("read-back moved while disabled");
  cover property ($rose(pll_reconfig_done_out[0]));
  cover property ($rose(pll_reconfig_done_out[1]));
  cover property ($rose(pll_locked_out[1]));
endmodule

bind pll_scan_reconfig pll_scan_checker chk_u (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in),
  .pll_areset_in(pll_areset_in), .pll_scanclk_in(pll_scanclk_in), .pll_scanclkena_in(pll_scanclkena_in),
  .pll_configupdate_in(pll_configupdate_in), .pll_reconfig_done_out(pll_reconfig_done_out),
  .pll_scandataout_out(pll_scandataout_out), .pll_locked_out(pll_locked_out), .chan_cfg_out(chan_cfg_out));

// ===== test/pll_ctl_model.sv
/* Reconfiguration controller model: shifts a setting in, strobes update, resets the PLL.
 Assumes the caller passes a PLL index below NUM_PLLS; scan clock idles low between frames. */
`timescale 1ns/1ps
module pll_ctl_model (
  input wire logic clk_in, // Bench clock
  input wire logic [1:0] done_in, // Reprogramming done
  output logic [1:0] areset_out, // PLL reset
  output logic [1:0] sd_out, // Scan data
  output logic [1:0] sck_out, // Scan clock, 320 ns
  output logic [1:0] ena_out, // Scan enable
  output logic [1:0] cu_out // Update strobe
);
  initial {areset_out, sd_out, sck_out, ena_out, cu_out} = '0;
  task automatic frame(input int i, input pll_scan_pkg::pll_cfg_t c, input logic en);
    @(posedge clk_in);
    // Data moves with the falling scan edge: 4 cycles low, 4 high, 320 ns
    for (int k = 0; k < pll_scan_pkg::CHAIN_LEN; k++) begin
      sd_out[i] <= c[k];
      ena_out[i] <= en;
      sck_out[i] <= 1'b0;
      repeat (4) @(posedge clk_in);
      sck_out[i] <= 1'b1;
      repeat (4) @(posedge clk_in);
    end
    // Scan clock parks low; released line shows the inverse, not a stale value
    sck_out[i] <= 1'b0;
    ena_out[i] <= 1'b0;
    sd_out[i] <= ~c[pll_scan_pkg::CHAIN_LEN-1];
  endtask
  task automatic apply(input int i, output logic ok);
    ok = 1'b0;
    @(posedge clk_in) cu_out[i] <= 1'b1;
    for (int n = 0; n < 20 && !ok; n++) begin
      @(posedge clk_in) ok = done_in[i];
    end
    cu_out[i] <= 1'b0;
    areset_out[i] <= ok;
    repeat (6) @(posedge clk_in);
    areset_out[i] <= 1'b0;
  endtask
endmodule

// ===== test/testbench.sv
/* Self-checking bench: random settings shifted into both PLLs, checked at channels.
 Assumes the controller model drives every scan pin of the block. */
`timescale 1ns/1ps
module testbench;
  typedef pll_scan_pkg::pll_cfg_t [1:0] cfg_pair_t;
  logic clk_sys_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic [1:0] ar, sd, sck, ena, cu, done, sdo, lk, lk_q;
  cfg_pair_t chan, cur, exp_q[$];
  int fails = 0;
  int n_checks = 0;
  int seed = 60;
  logic ok;
  logic [31:0] v;
  always #20 clk_sys_in = ~clk_sys_in;
  pll_scan_reconfig dut_u (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .pll_areset_in(ar),
    .pll_scandata_in(sd), .pll_scanclk_in(sck), .pll_scanclkena_in(ena), .pll_configupdate_in(cu),
    .pll_reconfig_done_out(done), .pll_scandataout_out(sdo), .pll_locked_out(lk), .chan_cfg_out(chan));
  pll_ctl_model ctl_u (.clk_in(clk_sys_in), .done_in(done), .areset_out(ar), .sd_out(sd),
    .sck_out(sck), .ena_out(ena), .cu_out(cu));
  task automatic check(input logic good, input string msg);
    n_checks++;
    if (!good) begin
      fails++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask
  task automatic print_verdict;
    if (fails == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Each newly locked PLL must show the oldest expected pair on all channels
  always @(posedge clk_sys_in) begin
    lk_q <= lk;
    if ((lk & ~lk_q) != 2'h0) begin
      if (exp_q.size() == 0)
        check(1'b0, "lock with nothing expected");
      else
        check(chan === exp_q.pop_front(), "channel settings");
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    cur = {pll_scan_pkg::CHAIN_RESET, pll_scan_pkg::CHAIN_RESET};
    exp_q.push_back(cur);
    repeat (6) @(posedge clk_sys_in);
    arst_n_in <= 1'b1;
    repeat (10) @(posedge clk_sys_in);
    for (int t = 0; t < 6; t++) begin
      // Every rate code is taken as legal for the channel mode
      v = $random(seed);
      // One frame with the enable low must leave the chain alone
      ctl_u.frame(t % 2, v[17:0], t != 3);
      if (t != 3)
        cur[t % 2] = v[17:0];
      repeat (6) @(posedge clk_sys_in);
      check(sdo[t % 2] === cur[t % 2][0], "read-back bit");
      exp_q.push_back(cur);
      ctl_u.apply(t % 2, ok);
      check(ok === 1'b1, "done timeout");
      // Over 4 us of settling after lock before the next frame
      repeat (104) @(posedge clk_sys_in);
    end
    check(exp_q.size() == 0, "missing lock");
    print_verdict();
  end
endmodule
